//--- scc_pkg.sv
// Constants, register map and encodings of the system clock control block
// Functional notes
// - Host mode uses the system input clock.
// - Sync output carries full or halved input.
// - Three PCI clock outputs in host mode.
// - PCI clocks disabled and low after reset.
// - Each PCI clock starts on its enable bit.
// - Enabled PCI clocks stay phase aligned.
// - Agent mode leaves PCI and sync outputs idle.
// - Three internal clock domains are derived.
// - Bus ratio is sync times halving times multiplier.
// - Core ratio comes from the core field.
// - Multipliers taken from reset configuration word.
// - Engine clock set by multiplier and divider.
// - Memory clock pair is controller clock halved.
// - Local bus clock divided by 2, 4, 8.
// - Local bus source runs 1x or 2x.
// - Unit clocks default full; off, half, third.
// - System multiplier codes 2 to 6 valid, engine multiplier codes 2 to 8; others reserved.
// - Core field middle zero bypasses core loop.
`default_nettype none
package scc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_OUT_CLOCK_CTRL  = 8'h00;
  localparam logic [7:0] OFS_UNIT_RATIO      = 8'h04;
  localparam logic [7:0] OFS_LOCAL_BUS_RATIO = 8'h08;
  localparam logic [7:0] OFS_STATUS          = 8'h0C;

  // Values after reset
  localparam logic [2:0] RST_OUT_CLOCK_CTRL  = 3'h0;
  localparam logic [7:0] RST_UNIT_RATIO      = 8'h55;
  localparam logic [1:0] RST_LOCAL_BUS_RATIO = 2'h0;

  // Fields of the reset configuration word low
  localparam int SYSTEM_PLL_MULTIPLIER_LSB  = 0;
  localparam int CORE_LSB  = 4;
  localparam int ENGM_LSB  = 11;
  localparam int ENGD_BIT  = 16;
  localparam int LOCAL_BUS_CLOCK_MODE_BIT  = 17;

  // Valid system multiplier codes
  localparam logic [3:0] SYSTEM_PLL_MULTIPLIER_MIN = 4'h2;
  localparam logic [3:0] SYSTEM_PLL_MULTIPLIER_MAX = 4'h6;
  // Valid engine multiplier codes
  localparam logic [4:0] ENGM_MIN = 5'h02;
  localparam logic [4:0] ENGM_MAX = 5'h08;

  // Cycles after reset release before straps are caught
  localparam logic [1:0] CAPTURE_CYCLE = 2'h2;

  // Local bus divide selector codes
  localparam logic [1:0] LB_DIV2 = 2'h0;
  localparam logic [1:0] LB_DIV4 = 2'h1;

  localparam int NUM_PCI   = 3;
  localparam int NUM_UNITS = 4;

  // Per-unit clock ratio codes
  typedef enum logic [1:0] {
    scc_off   = 2'b00,
    scc_full  = 2'b01,
    scc_half  = 2'b10,
    scc_third = 2'b11
  } scc_ratio_t;

endpackage : scc_pkg
`default_nettype wire

//--- scc_top.sv
// System clock control: clock selection, gating, dividers and registers
`default_nettype none
module scc_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        host_mode_select,
  input  wire logic        input_clock_halve_select,
  input  wire logic [31:0] reset_config_word_low,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             sync_clk_out,
  output logic      [2:0]  pci_clk_out,
  output logic             csb_clk_phase,
  output logic             ddr_clk_phase,
  output logic             lbc_clk_phase,
  output logic             memory_clk_p,
  output logic             memory_clk_n,
  output logic             local_bus_clock_out,
  output logic      [3:0]  unit_clk_en,
  output logic      [3:0]  csb_ratio,
  output logic      [2:0]  system_pll_multiplier,
  output logic             config_error,
  output logic      [6:0]  core_pll_ratio,
  output logic             core_pll_bypass,
  output logic      [4:0]  engine_pll_multiplier,
  output logic             engine_pll_divider,
  output logic             engine_config_error
);

  // Pin synchronisers; first stages feed only the second stages
  logic       host_meta;
  logic       host_sync;
  logic       halve_meta;
  logic       halve_sync;
  // Latched straps and configuration word
  logic       cfg_loaded;
  logic [1:0] cfg_cnt;
  logic       host_mode;
  logic       halve_n;
  logic [31:0] cfg_word;
  // Software registers
  logic [2:0] output_clock_control;
  logic [7:0] unit_ratio;
  logic [1:0] local_bus_clock_ratio_reg;
  // Clock generation state
  logic [1:0] div_cnt;
  logic [3:0] lb_cnt;
  logic [1:0] third_cnt;
  logic [2:0] pci_en_act;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_meta  <= 1'b0;
      host_sync  <= 1'b0;
      halve_meta <= 1'b0;
      halve_sync <= 1'b0;
    end else begin
      host_meta  <= host_mode_select;
      host_sync  <= host_meta;
      halve_meta <= input_clock_halve_select;
      halve_sync <= halve_meta;
    end
  end

  // Straps caught once the synchronisers have filled after release
  // A strap change after capture waits for the next reset to matter
  wire capture_now = !cfg_loaded && (cfg_cnt == scc_pkg::CAPTURE_CYCLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_cnt    <= 2'h0;
      cfg_loaded <= 1'b0;
      host_mode  <= 1'b0;
      halve_n    <= 1'b0;
      cfg_word   <= 32'h0000_0000;
    end else begin
      cfg_cnt <= cfg_loaded ? cfg_cnt : cfg_cnt + 2'h1;
      if (capture_now) begin
        cfg_loaded <= 1'b1;
        host_mode  <= host_sync;
        halve_n    <= !halve_sync;
        cfg_word   <= reset_config_word_low;
      end
    end
  end

  // Configuration field decode
  wire [3:0] system_pll_multiplier_code  = cfg_word[scc_pkg::SYSTEM_PLL_MULTIPLIER_LSB +: 4];
  wire [6:0] core_code  = cfg_word[scc_pkg::CORE_LSB +: 7];
  wire [4:0] engm_code  = cfg_word[scc_pkg::ENGM_LSB +: 5];
  wire       engd_bit   = cfg_word[scc_pkg::ENGD_BIT];
  wire       lb_fast    = cfg_word[scc_pkg::LOCAL_BUS_CLOCK_MODE_BIT];
  wire       system_pll_multiplier_ok    = (system_pll_multiplier_code >= scc_pkg::SYSTEM_PLL_MULTIPLIER_MIN) &&
                          (system_pll_multiplier_code <= scc_pkg::SYSTEM_PLL_MULTIPLIER_MAX);
  wire [2:0] system_pll_multiplier_fac   = system_pll_multiplier_ok ? system_pll_multiplier_code[2:0] : 3'h0;
  wire [3:0] next_ratio = halve_n ? {system_pll_multiplier_fac, 1'b0} : {1'b0, system_pll_multiplier_fac};
  wire       engm_ok    = (engm_code >= scc_pkg::ENGM_MIN) &&
                          (engm_code <= scc_pkg::ENGM_MAX);
  wire       bypass     = (core_code[4:1] == 4'h0);

  // Register decode
  wire sel_occ  = (reg_addr == scc_pkg::OFS_OUT_CLOCK_CTRL);
  wire sel_unit = (reg_addr == scc_pkg::OFS_UNIT_RATIO);
  wire sel_lbr  = (reg_addr == scc_pkg::OFS_LOCAL_BUS_RATIO);
  wire sel_stat = (reg_addr == scc_pkg::OFS_STATUS);
  wire [31:0] status_word = {16'h0000, engine_config_error, config_error,
                             core_pll_bypass, lb_fast, csb_ratio,
                             system_pll_multiplier, halve_n, 2'h0,
                             cfg_loaded, host_mode};
  wire [31:0] next_rdata =
      !reg_rd  ? 32'h0000_0000 :
      sel_occ  ? {29'h0, output_clock_control} :
      sel_unit ? {24'h0, unit_ratio} :
      sel_lbr  ? {30'h0, local_bus_clock_ratio_reg} :
      sel_stat ? status_word : 32'h0000_0000;

  // Register writes; unit ratios must be set before the unit is used
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_clock_control      <= scc_pkg::RST_OUT_CLOCK_CTRL;
      unit_ratio                <= scc_pkg::RST_UNIT_RATIO;
      local_bus_clock_ratio_reg <= scc_pkg::RST_LOCAL_BUS_RATIO;
      reg_rdata                 <= 32'h0000_0000;
    end else begin
      if (reg_wr && sel_occ)
        output_clock_control <= reg_wdata[2:0];
      if (reg_wr && sel_unit)
        unit_ratio <= reg_wdata[7:0];
      if (reg_wr && sel_lbr)
        local_bus_clock_ratio_reg <= reg_wdata[1:0];
      reg_rdata <= next_rdata;
    end
  end

  // Shared divider: bit 0 is the controller rate, bit 1 the bus rate
  wire [1:0] next_div   = div_cnt + 2'h1;
  wire       next_ref   = halve_n ? next_div[1] : next_div[0];
  wire       lb_tick    = lb_fast ? 1'b1 : div_cnt[0];
  wire [3:0] next_lb    = lb_tick ? lb_cnt + 4'h1 : lb_cnt;
  wire       next_local_bus_clock_out  =
      (local_bus_clock_ratio_reg == scc_pkg::LB_DIV2) ? next_lb[1] :
      (local_bus_clock_ratio_reg == scc_pkg::LB_DIV4) ? next_lb[2] :
      next_lb[3];
  wire       next_lbc   = lb_fast ? next_div[0] : next_div[1];
  wire [1:0] next_third = (third_cnt == 2'h2) ? 2'h0 : third_cnt + 2'h1;

  // One counter drives all clock outputs except local_bus_clock_out, which runs from lb_cnt, so they stay in phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt             <= 2'h0;
      lb_cnt              <= 4'h0;
      third_cnt           <= 2'h0;
      sync_clk_out        <= 1'b0;
      csb_clk_phase       <= 1'b0;
      ddr_clk_phase       <= 1'b0;
      lbc_clk_phase       <= 1'b0;
      memory_clk_p        <= 1'b0;
      memory_clk_n        <= 1'b1;
      local_bus_clock_out <= 1'b0;
    end else begin
      div_cnt             <= next_div;
      lb_cnt              <= next_lb;
      third_cnt           <= next_third;
      sync_clk_out        <= host_mode & next_ref;
      csb_clk_phase       <= next_div[1];
      ddr_clk_phase       <= next_div[0];
      lbc_clk_phase       <= next_lbc;
      memory_clk_p        <= next_div[1];
      memory_clk_n        <= !next_div[1];
      local_bus_clock_out <= next_local_bus_clock_out;
    end
  end

  // PCI outputs; enables follow software only while the clock is low
  genvar gi;
  generate
    for (gi = 0; gi < scc_pkg::NUM_PCI; gi++) begin : g_pci
      wire want = host_mode & output_clock_control[gi];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pci_en_act[gi]  <= 1'b0;
          pci_clk_out[gi] <= 1'b0;
        end else begin
          if (!next_ref)
            pci_en_act[gi] <= want;
          pci_clk_out[gi] <= next_ref & (next_ref ? pci_en_act[gi] : 1'b0);
        end
      end
    end
  endgenerate

  // Unit clock enables per ratio code
  generate
    for (gi = 0; gi < scc_pkg::NUM_UNITS; gi++) begin : g_unit
      wire [1:0] code = unit_ratio[2*gi +: 2];
      wire next_en =
          (code == scc_pkg::scc_full)  ? 1'b1 :
          (code == scc_pkg::scc_half)  ? next_div[0] :
          (code == scc_pkg::scc_third) ? (next_third == 2'h0) : 1'b0;
      always_ff @(posedge clk or posedge rst) begin
        if (rst)
          unit_clk_en[gi] <= 1'b1;
        else
          unit_clk_en[gi] <= next_en;
      end
    end
  endgenerate

  // Decoded multiplier outputs; out-of-range multiplier codes give zero and set an error flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csb_ratio             <= 4'h0;
      system_pll_multiplier <= 3'h0;
      config_error          <= 1'b0;
      core_pll_ratio        <= 7'h00;
      core_pll_bypass       <= 1'b0;
      engine_pll_multiplier <= 5'h00;
      engine_pll_divider    <= 1'b0;
      engine_config_error   <= 1'b0;
    end else begin
      csb_ratio             <= next_ratio;
      system_pll_multiplier <= system_pll_multiplier_fac;
      config_error          <= cfg_loaded & !system_pll_multiplier_ok;
      core_pll_ratio        <= core_code;
      core_pll_bypass       <= cfg_loaded & bypass;
      engine_pll_multiplier <= engm_ok ? engm_code : 5'h00;
      engine_pll_divider    <= engd_bit;
      engine_config_error   <= cfg_loaded & !engm_ok;
    end
  end

  // Unit checks wait out a ratio change, since enables lag the code by one edge
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pci_agent_idle_a: assert property (
    !host_mode && cfg_loaded |=> (pci_clk_out == 3'h0) && !sync_clk_out)
    else $error("pci or sync clock active in agent mode");

  pci_off_low_a: assert property (
    !output_clock_control[0] [*4] |-> !pci_clk_out[0])
    else $error("disabled pci clock not low");

  pci_start_a: assert property (
    $rose(pci_clk_out[1]) |-> $past(output_clock_control[1], 2) && host_mode)
    else $error("pci clock started without enable");

  pci_align_a: assert property (
    (&pci_en_act) |-> (pci_clk_out == {3{pci_clk_out[0]}}))
    else $error("pci clocks out of phase");

  pci_width_a: assert property (
    halve_n && $rose(pci_clk_out[0]) |=> pci_clk_out[0])
    else $error("short pci clock pulse");

  mem_pair_a: assert property (
    memory_clk_p != memory_clk_n)
    else $error("memory clock pair not complementary");

  mem_period_a: assert property (
    $rose(memory_clk_p) |=> memory_clk_p ##1 !memory_clk_p)
    else $error("memory clock period wrong");

  local_bus_clock_out_div2_a: assert property (
    (lb_fast && (local_bus_clock_ratio_reg == scc_pkg::LB_DIV2)) [*3]
    ##0 $rose(local_bus_clock_out) |=> local_bus_clock_out ##1 !local_bus_clock_out)
    else $error("local bus clock divide by two wrong");

  unit_third_a: assert property (
    (unit_ratio[7:6] == 2'h3) [*4] ##0 $past(unit_clk_en[3], 2)
    |-> !$past(unit_clk_en[3]) && !unit_clk_en[3])
    else $error("third rate unit enable wrong");

  unit_off_a: assert property (
    (unit_ratio[1:0] == 2'h0) |=> !unit_clk_en[0])
    else $error("unit clock enabled while off");

  csb_ratio_a: assert property (
    ##1 cfg_loaded |-> csb_ratio == (halve_n ? {$past(system_pll_multiplier_fac), 1'b0} : {1'b0, $past(system_pll_multiplier_fac)}))
    else $error("bus ratio mismatch");

  sync_full_a: assert property (
    cfg_loaded && $past(cfg_loaded) && host_mode && !halve_n
    |=> sync_clk_out != $past(sync_clk_out))
    else $error("full rate sync clock not toggling");

  sync_half_a: assert property (
    cfg_loaded && $past(cfg_loaded) && host_mode && halve_n && $rose(sync_clk_out)
    |=> sync_clk_out ##1 !sync_clk_out)
    else $error("halved sync clock period wrong");

  ddr_toggle_a: assert property (
    cfg_loaded |-> ddr_clk_phase != $past(ddr_clk_phase))
    else $error("controller clock not toggling");

  unit_half_a: assert property (
    (unit_ratio[5:4] == 2'h2) [*3] |-> unit_clk_en[2] != $past(unit_clk_en[2]))
    else $error("half rate unit enable wrong");

  bypass_match_a: assert property (
    cfg_loaded && $past(cfg_loaded) |-> core_pll_bypass == (core_pll_ratio[4:1] == 4'h0))
    else $error("core bypass does not match ratio field");

endmodule // scc_top
`default_nettype wire

//--- scc_pci_agent.sv
// External PCI agent model that receives the three generated PCI clocks
`default_nettype none
module scc_pci_agent (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] pci_clk,
  input  wire logic [1:0] min_high,
  output int              short_pulses
);
  timeunit 1ns;
  timeprecision 100ps;
  int high_len [3];

  // Measure each high phase; a clipped enable or disable shows up as a short one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      short_pulses = 0;
      for (int i = 0; i < 3; i++) high_len[i] = 0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pci_clk[i] === 1'b1) begin
          high_len[i]++;
        end else if (high_len[i] > 0) begin
          if (high_len[i] < int'(min_high)) short_pulses++;
          high_len[i] = 0;
        end
      end
    end
  end
endmodule // scc_pci_agent
`default_nettype wire

//--- test_system_clock_control.sv
// Self-checking bench for the system clock control block
`default_nettype none
module test_system_clock_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        host_mode_select = 1'b1;
  logic        input_clock_halve_select = 1'b0;
  logic [31:0] reset_config_word_low = 32'h0000_0044;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        sync_clk_out, csb_clk_phase, ddr_clk_phase, lbc_clk_phase;
  logic        memory_clk_p, memory_clk_n, local_bus_clock_out;
  logic        config_error, core_pll_bypass, engine_pll_divider, engine_config_error;
  logic [2:0]  pci_clk_out, system_pll_multiplier;
  logic [3:0]  unit_clk_en, csb_ratio;
  logic [6:0]  core_pll_ratio;
  logic [4:0]  engine_pll_multiplier;
  int          short_pulses, failures = 0, samples_checked = 0;
  int          rises [9];
  int          hi [4];
  logic [8:0]  mon, mon_q = 9'h0;

  scc_top DUT (.clk(clk), .rst(rst), .host_mode_select(host_mode_select),
    .input_clock_halve_select(input_clock_halve_select),
    .reset_config_word_low(reset_config_word_low), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_clk_out(sync_clk_out), .pci_clk_out(pci_clk_out), .csb_clk_phase(csb_clk_phase),
    .ddr_clk_phase(ddr_clk_phase), .lbc_clk_phase(lbc_clk_phase),
    .memory_clk_p(memory_clk_p), .memory_clk_n(memory_clk_n),
    .local_bus_clock_out(local_bus_clock_out), .unit_clk_en(unit_clk_en),
    .csb_ratio(csb_ratio), .system_pll_multiplier(system_pll_multiplier),
    .config_error(config_error), .core_pll_ratio(core_pll_ratio),
    .core_pll_bypass(core_pll_bypass), .engine_pll_multiplier(engine_pll_multiplier),
    .engine_pll_divider(engine_pll_divider), .engine_config_error(engine_config_error));

  scc_pci_agent agent (.clk(clk), .rst(rst), .pci_clk(pci_clk_out),
    .min_high(input_clock_halve_select ? 2'h1 : 2'h2), .short_pulses(short_pulses));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Edge counters for every generated waveform except memory_clk_n, duty counters for the unit enables
  assign mon = {pci_clk_out, local_bus_clock_out, memory_clk_p, lbc_clk_phase,
                ddr_clk_phase, csb_clk_phase, sync_clk_out};
  always @(posedge clk) begin
    mon_q <= mon;
    for (int i = 0; i < 9; i++) if (mon[i] === 1'b1 && mon_q[i] === 1'b0) rises[i]++;
    for (int u = 0; u < 4; u++) if (unit_clk_en[u] === 1'b1) hi[u]++;
  end

  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // Window counts depend on phase, so one edge either way is accepted
  function automatic bit near(input int got, input int exp);
    return (got - exp <= 1) && (exp - got <= 1);
  endfunction

  task automatic window(input int n);
    #1;
    for (int i = 0; i < 9; i++) rises[i] = 0;
    for (int u = 0; u < 4; u++) hi[u] = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Straps are latched once, so each configuration needs its own reset
  task automatic do_reset(input logic host, input logic halve, input logic [31:0] word);
    @(posedge clk);
    rst <= 1'b1;
    host_mode_select <= host;
    input_clock_halve_select <= halve;
    reset_config_word_low <= word;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata === exp, "register read mismatch");
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the roughly 1400 cycles the sequence needs
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    end_of_test;
  end

  initial begin
    logic [3:0]  m;
    logic [4:0]  em;
    logic [6:0]  core;
    logic [31:0] w;
    bit          ok, ev;
    int          n;
    // Sweep multiplier codes 0 to 7 with varied halving, bypass, engine and local bus mode
    for (int k = 0; k < 8; k++) begin
      m = 4'(k);
      em = 5'(k + 1);
      core = (k == 3) ? 7'h00 : 7'h04;
      w = {14'h0, m[2], m[1], em, core, m};
      do_reset(1'b1, m[0], w);
      ok = (m >= 4'h2) && (m <= 4'h6);
      ev = (em >= 5'h02) && (em <= 5'h08);
      chk(system_pll_multiplier === (ok ? m[2:0] : 3'h0), "sys mult");
      chk(config_error === !ok, "cfg err");
      chk(csb_ratio === (ok ? (m[0] ? m : 4'(m * 2)) : 4'h0), "csb ratio");
      chk(core_pll_ratio === core && core_pll_bypass === (k == 3), "core");
      chk(core_pll_bypass === (core[4:1] === 4'h0), "bypass");
      chk(engine_pll_multiplier === (ev ? em : 5'h00), "eng mult");
      chk(engine_config_error === !ev && engine_pll_divider === m[1], "eng");
      window(40);
      chk(near(rises[0], m[0] ? 20 : 10), "sync rate");
      chk(near(rises[1], 10) && near(rises[2], 20), "csb and ddr rates");
      chk(near(rises[3], m[2] ? 20 : 10), "local bus source");
      chk(near(rises[4], 10) && memory_clk_p === !memory_clk_n, "memory pair");
    end
    // Host mode, halved reference, multiplier four
    do_reset(1'b1, 1'b0, 32'h0000_0044);
    window(20);
    chk(pci_clk_out === 3'h0 && rises[6] + rises[7] + rises[8] == 0, "pci idle");
    chk(unit_clk_en === 4'hF, "unit enables default");
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h55);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0000_8893);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_8893);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    wr(8'h00, 32'h1);
    n = 0;
    while (pci_clk_out[0] !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(pci_clk_out[0] === 1'b1, "pci0 start");
    window(40);
    chk(near(rises[6], 10) && rises[7] == 0 && rises[8] == 0, "only pci0");
    wr(8'h00, 32'h7);
    repeat (8) @(posedge clk);
    for (int c = 0; c < 20; c++) begin
      #1;
      chk(pci_clk_out === 3'h0 || pci_clk_out === 3'h7, "pci alignment");
      chk(pci_clk_out[0] === sync_clk_out, "pci follows sync");
      @(posedge clk);
    end
    rd(8'h00, 32'h7);
    wr(8'h00, 32'h0);
    repeat (8) @(posedge clk);
    window(20);
    chk(pci_clk_out === 3'h0 && rises[6] == 0, "pci disabled");
    chk(short_pulses == 0, "short pci pulse");
    // Unit ratios programmed before any unit access
    wr(8'h04, 32'hE4);
    rd(8'h04, 32'hE4);
    window(60);
    chk(hi[0] == 0 && near(hi[1], 60) && near(hi[2], 30) && near(hi[3], 20), "units");
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, 32'(c));
      repeat (16) @(posedge clk);
      window(160);
      chk(near(rises[5], (c == 0) ? 20 : (c == 1) ? 10 : 5), "local bus divide");
    end
    // Agent mode with the system input held low
    do_reset(1'b0, 1'b0, 32'h0000_0044);
    wr(8'h00, 32'h7);
    window(40);
    chk(rises[0] == 0 && rises[6] + rises[7] + rises[8] == 0, "agent idle");
    chk(pci_clk_out === 3'h0 && sync_clk_out === 1'b0, "agent low");
    end_of_test;
  end
endmodule // test_system_clock_control
`default_nettype wire
